// [logic/queue_region_regs.svh]
// register offsets, field positions, reset values for the queue region bank
// assumes inclusion by bare name from the design and bench files
`ifndef QUEUE_REGION_REGS_SVH
`define QUEUE_REGION_REGS_SVH
`define WAN_Q16_END_OFS 9'h17e
`define LAN_INS_START_OFS 9'h180
`define LAN_INS_END_OFS 9'h182
`define LAN_EXT_START_OFS 9'h184
`define LAN_EXT_END_OFS 9'h186
`define WAN_INS_START_OFS 9'h188
`define WAN_INS_END_OFS 9'h18a
`define WAN_EXT_START_OFS 9'h18c
`define WAN_EXT_END_OFS 9'h18e
`define LAN_WMARK_OFS 9'h190
`define MISC_CTRL_OFS 9'h192
`define ADDR_FIELD_W 10
`define PTR_RESET_BIT 10
`define WMARK_W 13
`define WMARK_UNIT_BYTES 64
`define REGION_UNIT_BYTES 32768
`define REG_RESET 16'h0000
`define MISC_ALL_RESET_BIT 0
`define MISC_PREEMPT_BIT 1
`define MISC_INS_EN_BIT 2
`define MISC_INS_PRIO_BIT 3
`define MISC_ENCAP_LSB 4
`define MISC_RR_LSB 6
`define MISC_OVF_OFF_BIT 8
`define MISC_PURGE_OFF_BIT 9
`define MISC_RW_MASK 16'h03fe
`endif

// [logic/queue_region_pkg.sv]
// types shared by the queue region register bank
// assumes the offsets header sits beside it
package queue_region_pkg;
  // one queue region: start and end in 32 KiB units
  typedef struct packed {
    logic [9:0] start_field;
    logic [9:0] end_field;
  } region_t;
  // register bus request
  typedef struct packed {
    logic [8:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  // queue index order for regions and pointers
  typedef enum logic [1:0] {Q_LAN_INS, Q_LAN_EXT, Q_WAN_INS, Q_WAN_EXT} queue_id_t;
  // whole module state
  typedef struct packed {
    logic [9:0] wan_q16_end_field;
    region_t [3:0] region;
    logic [12:0] lan_fill_threshold;
    logic [15:0] misc;
    logic [3:0][9:0] ptr;
    logic [3:0] ptr_reset;
    logic [15:0] rdata;
    logic [15:0] pause_req;
    logic [15:0] wmark_event;
  } state_t;
endpackage : queue_region_pkg

// [logic/queue_region_config.sv]
// queue region configuration bank: SDRAM queue bounds, pointer resets,
// LAN watermark comparison and miscellaneous queue control.
// assumes one 125 MHz clock, async active-high reset, plain strobe bus.
//
// Functional notes
// - start and end fields are 10 bits, one step is 32768 bytes
// - writable end field for WAN queue sixteen
// - LAN insert queue start and end fields bound its region
// - LAN extract queue start and end fields bound its region
// - WAN insert queue start and end fields bound its region
// - WAN extract queue start and end fields bound its region
// - writing one to start bit 10 pulses that queue's pointer reset
// - writing zero to bit 10 leaves pointers alone
// - 13-bit LAN watermark; crossing it requests a pause frame
// - one watermark shared by sixteen independently enabled LAN queues
// - watermark times 64 is the free-byte reserve at trigger
// - reaching watermark also raises the watermark interrupt condition
// - watermark flow control uses fill level only, not rate policing
// - misc bit 9 zero enables partial frame purge, one disables
// - all-queue reset bit pulses every queue pointer reset at once
// - misc bit 8 zero discards overflowing WAN queue, one disables
`include "queue_region_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module queue_region_config #(
  parameter int QUEUES = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [8:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [3:0] ptr_advance,
  input wire logic [QUEUES-1:0] lan_q_enable,
  input wire logic [QUEUES*16-1:0] lan_q_free_units,
  output logic [15:0] rdata,
  output logic [9:0] wan_q16_end_field,
  output logic [79:0] region_bounds,
  output logic [39:0] queue_ptr,
  output logic [3:0] queue_ptr_reset,
  output logic all_queue_ptr_reset,
  output logic [12:0] lan_fill_threshold,
  output logic [QUEUES-1:0] pause_req,
  output logic [QUEUES-1:0] wmark_event,
  output logic partial_frame_purge_off,
  output logic wan_overflow_drop_off,
  output logic wan_preemptive_drop,
  output logic wan_ins_enable,
  output logic wan_ins_priority_level,
  output logic [1:0] wan_ins_encap_select,
  output logic [1:0] wan_ins_rr_weight
);
  queue_region_pkg::state_t state_reg;
  queue_region_pkg::state_t state_next;
  queue_region_pkg::bus_req_t req;
  logic [QUEUES-1:0] below_mark;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // per-queue comparison against the shared watermark
  genvar gi;
  generate
    for (gi = 0; gi < QUEUES; gi++) begin : g_mark
      assign below_mark[gi] = lan_q_enable[gi] &&
        (lan_q_free_units[gi*16 +: 16] <= {3'h0, state_reg.lan_fill_threshold});
    end
  endgenerate

  // next state: register writes, pointer pulses, pointer walk, readback
  always_comb begin
    logic all_rst;
    logic [3:0] q_rst;
    state_next = state_reg;
    all_rst = 1'b0;
    q_rst = 4'h0;
    state_next.rdata = 16'h0000;
    if (req.wr) begin
      if (req.addr == `WAN_Q16_END_OFS) begin
        state_next.wan_q16_end_field = req.wdata[9:0];
      end else if (req.addr == `LAN_INS_START_OFS) begin
        state_next.region[0].start_field = req.wdata[9:0];
        q_rst[0] = req.wdata[`PTR_RESET_BIT];
      end else if (req.addr == `LAN_INS_END_OFS) begin
        state_next.region[0].end_field = req.wdata[9:0];
      end else if (req.addr == `LAN_EXT_START_OFS) begin
        state_next.region[1].start_field = req.wdata[9:0];
        q_rst[1] = req.wdata[`PTR_RESET_BIT];
      end else if (req.addr == `LAN_EXT_END_OFS) begin
        state_next.region[1].end_field = req.wdata[9:0];
      end else if (req.addr == `WAN_INS_START_OFS) begin
        state_next.region[2].start_field = req.wdata[9:0];
        q_rst[2] = req.wdata[`PTR_RESET_BIT];
      end else if (req.addr == `WAN_INS_END_OFS) begin
        state_next.region[2].end_field = req.wdata[9:0];
      end else if (req.addr == `WAN_EXT_START_OFS) begin
        state_next.region[3].start_field = req.wdata[9:0];
        q_rst[3] = req.wdata[`PTR_RESET_BIT];
      end else if (req.addr == `WAN_EXT_END_OFS) begin
        state_next.region[3].end_field = req.wdata[9:0];
      end else if (req.addr == `LAN_WMARK_OFS) begin
        state_next.lan_fill_threshold = req.wdata[12:0];
      end else if (req.addr == `MISC_CTRL_OFS) begin
        state_next.misc = req.wdata & `MISC_RW_MASK;
        all_rst = req.wdata[`MISC_ALL_RESET_BIT];
      end
    end
    // self-clearing pulses: high one cycle after the write
    state_next.ptr_reset = q_rst | {4{all_rst}};
    state_next.misc[`MISC_ALL_RESET_BIT] = all_rst;
    // circular pointer walk inside each region
    for (int q = 0; q < 4; q++) begin
      if (state_reg.ptr_reset[q]) begin
        state_next.ptr[q] = state_reg.region[q].start_field;
      end else if (ptr_advance[q]) begin
        if (state_reg.ptr[q] == state_reg.region[q].end_field) begin
          state_next.ptr[q] = state_reg.region[q].start_field;
        end else begin
          state_next.ptr[q] = 10'(state_reg.ptr[q] + 10'h001);
        end
      end
    end
    // watermark: pause level plus one-cycle crossing event
    state_next.pause_req = 16'(below_mark);
    state_next.wmark_event = 16'(below_mark) & ~state_reg.pause_req;
    if (req.rd) begin
      if (req.addr == `WAN_Q16_END_OFS) begin
        state_next.rdata = {6'h00, state_reg.wan_q16_end_field};
      end else if (req.addr == `LAN_INS_START_OFS) begin
        state_next.rdata = {6'h00, state_reg.region[0].start_field};
      end else if (req.addr == `LAN_INS_END_OFS) begin
        state_next.rdata = {6'h00, state_reg.region[0].end_field};
      end else if (req.addr == `LAN_EXT_START_OFS) begin
        state_next.rdata = {6'h00, state_reg.region[1].start_field};
      end else if (req.addr == `LAN_EXT_END_OFS) begin
        state_next.rdata = {6'h00, state_reg.region[1].end_field};
      end else if (req.addr == `WAN_INS_START_OFS) begin
        state_next.rdata = {6'h00, state_reg.region[2].start_field};
      end else if (req.addr == `WAN_INS_END_OFS) begin
        state_next.rdata = {6'h00, state_reg.region[2].end_field};
      end else if (req.addr == `WAN_EXT_START_OFS) begin
        state_next.rdata = {6'h00, state_reg.region[3].start_field};
      end else if (req.addr == `WAN_EXT_END_OFS) begin
        state_next.rdata = {6'h00, state_reg.region[3].end_field};
      end else if (req.addr == `LAN_WMARK_OFS) begin
        state_next.rdata = {3'h0, state_reg.lan_fill_threshold};
      end else if (req.addr == `MISC_CTRL_OFS) begin
        state_next.rdata = state_reg.misc & `MISC_RW_MASK;
      end
    end
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from state
  assign rdata = state_reg.rdata;
  assign wan_q16_end_field = state_reg.wan_q16_end_field;
  assign region_bounds = state_reg.region;
  assign queue_ptr = state_reg.ptr;
  assign queue_ptr_reset = state_reg.ptr_reset;
  assign all_queue_ptr_reset = state_reg.misc[`MISC_ALL_RESET_BIT];
  assign lan_fill_threshold = state_reg.lan_fill_threshold;
  assign pause_req = state_reg.pause_req[QUEUES-1:0];
  assign wmark_event = state_reg.wmark_event[QUEUES-1:0];
  assign partial_frame_purge_off = state_reg.misc[`MISC_PURGE_OFF_BIT];
  assign wan_overflow_drop_off = state_reg.misc[`MISC_OVF_OFF_BIT];
  assign wan_preemptive_drop = state_reg.misc[`MISC_PREEMPT_BIT];
  assign wan_ins_enable = state_reg.misc[`MISC_INS_EN_BIT];
  assign wan_ins_priority_level = state_reg.misc[`MISC_INS_PRIO_BIT];
  assign wan_ins_encap_select = state_reg.misc[`MISC_ENCAP_LSB +: 2];
  assign wan_ins_rr_weight = state_reg.misc[`MISC_RR_LSB +: 2];

  // write then read back, pulse timing, wrap checks
  sequence start_write_s;
    wr && addr == `LAN_INS_START_OFS;
  endsequence
  property ptr_pulse_p;
    @(posedge clock) disable iff (rst)
    start_write_s ##0 wdata[10] |=> queue_ptr_reset[0] ##1 !queue_ptr_reset[0] || wr;
  endproperty
  ins_ptr_pulse_a: assert property (ptr_pulse_p) else $error("ptr reset pulse wrong");
  no_pulse_zero_a: assert property (@(posedge clock) disable iff (rst)
    start_write_s ##0 !wdata[10] |=> !queue_ptr_reset[0])
    else $error("pointer reset without bit 10");
  all_reset_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `MISC_CTRL_OFS && wdata[0] |=> queue_ptr_reset == 4'hf && all_queue_ptr_reset)
    else $error("all queue reset missing");
  q16_store_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `WAN_Q16_END_OFS |=> wan_q16_end_field == $past(wdata[9:0]))
    else $error("queue 16 end not stored");
  wmark_read_a: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `LAN_WMARK_OFS |=> rdata == {3'h0, lan_fill_threshold})
    else $error("watermark readback wrong");
  purge_bit_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `MISC_CTRL_OFS |=> partial_frame_purge_off == $past(wdata[9]))
    else $error("purge control wrong");
  ovf_bit_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `MISC_CTRL_OFS |=> wan_overflow_drop_off == $past(wdata[8]))
    else $error("overflow discard control wrong");
  ptr_wrap_a: assert property (@(posedge clock) disable iff (rst)
    ptr_advance[0] && !queue_ptr_reset[0] && queue_ptr[9:0] == region_bounds[9:0]
    |=> queue_ptr[9:0] == $past(region_bounds[19:10]))
    else $error("pointer did not wrap");
  wmark_pause_a: assert property (@(posedge clock) disable iff (rst)
    lan_q_enable[0] && lan_q_free_units[15:0] <= {3'h0, lan_fill_threshold}
    && !(wr && addr == `LAN_WMARK_OFS) |=> pause_req[0])
    else $error("pause not requested");
  wmark_event_a: assert property (@(posedge clock) disable iff (rst)
    $rose(pause_req[0]) |-> wmark_event[0])
    else $error("watermark event missing");

  // read data is zero in every cycle that follows no read
  idle_read_a: assert property (@(posedge clock) disable iff (rst)
    !rd |=> rdata == 16'h0000)
    else $error("read data not cleared");

  // odd or unmapped addresses read back as zero
  unmapped_read_a: assert property (@(posedge clock) disable iff (rst)
    rd && (addr[0] || addr < `WAN_Q16_END_OFS || addr > `MISC_CTRL_OFS)
    |=> rdata == 16'h0000)
    else $error("unmapped read not zero");

  // queue sixteen end field readback
  q16_read_a: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `WAN_Q16_END_OFS |=> rdata == {6'h00, $past(wan_q16_end_field)})
    else $error("queue 16 end readback wrong");

  // watermark takes all thirteen written bits
  thr_store_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `LAN_WMARK_OFS |=> lan_fill_threshold == $past(wdata[12:0]))
    else $error("watermark not stored");

  // misc control bits 7..1 land on their outputs
  misc_store_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `MISC_CTRL_OFS |=> {wan_ins_rr_weight, wan_ins_encap_select,
      wan_ins_priority_level, wan_ins_enable, wan_preemptive_drop} == $past(wdata[7:1]))
    else $error("misc control not stored");

  // misc readback: stored bits 9..1, pulse bit and top bits zero
  misc_read_a: assert property (@(posedge clock) disable iff (rst)
    rd && addr == `MISC_CTRL_OFS |=> rdata == {6'h00, $past({partial_frame_purge_off,
      wan_overflow_drop_off, wan_ins_rr_weight, wan_ins_encap_select,
      wan_ins_priority_level, wan_ins_enable, wan_preemptive_drop}), 1'b0})
    else $error("misc readback wrong");

  // all-queue pulse lasts one cycle without a new write
  all_end_a: assert property (@(posedge clock) disable iff (rst)
    all_queue_ptr_reset && !wr |=> !all_queue_ptr_reset)
    else $error("all queue pulse stuck");

  // misc write with bit 0 low gives no all-queue pulse
  all_quiet_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `MISC_CTRL_OFS && !wdata[0] |=> !all_queue_ptr_reset)
    else $error("all queue pulse without bit 0");

  // configuration holds while nothing is written
  config_hold_a: assert property (@(posedge clock) disable iff (rst)
    !wr |=> $stable(region_bounds) && $stable(wan_q16_end_field)
      && $stable(lan_fill_threshold))
    else $error("configuration changed without write");

  // misc write leaves region bounds and watermark alone
  misc_only_a: assert property (@(posedge clock) disable iff (rst)
    wr && addr == `MISC_CTRL_OFS |=> $stable(region_bounds) && $stable(lan_fill_threshold))
    else $error("misc write disturbed other fields");

  // per-region checks: stores, readback, pulse, load, step, wrap, hold
  genvar qi;
  generate
    for (qi = 0; qi < 4; qi++) begin : g_region_chk
      localparam logic [8:0] START_OFS = 9'(`LAN_INS_START_OFS + 4 * qi);
      localparam logic [8:0] END_OFS = 9'(`LAN_INS_END_OFS + 4 * qi);

      // write to this queue's start register
      sequence start_wr_s;
        wr && addr == START_OFS;
      endsequence
      // write to this queue's end register
      sequence end_wr_s;
        wr && addr == END_OFS;
      endsequence
      // pointer advance away from the end address
      sequence mid_step_s;
        ptr_advance[qi] && !queue_ptr_reset[qi] &&
          queue_ptr[10*qi +: 10] != region_bounds[20*qi +: 10];
      endsequence

      // start field takes the written value
      start_store_a: assert property (@(posedge clock) disable iff (rst)
        start_wr_s |=> region_bounds[20*qi+10 +: 10] == $past(wdata[9:0]))
        else $error("start field not stored");
      // end field takes the written value
      end_store_a: assert property (@(posedge clock) disable iff (rst)
        end_wr_s |=> region_bounds[20*qi +: 10] == $past(wdata[9:0]))
        else $error("end field not stored");
      // start readback, upper bits zero
      start_read_a: assert property (@(posedge clock) disable iff (rst)
        rd && addr == START_OFS |=> rdata == {6'h00, $past(region_bounds[20*qi+10 +: 10])})
        else $error("start readback wrong");
      // end readback, upper bits zero
      end_read_a: assert property (@(posedge clock) disable iff (rst)
        rd && addr == END_OFS |=> rdata == {6'h00, $past(region_bounds[20*qi +: 10])})
        else $error("end readback wrong");
      // bit 10 pulses the reset, then the pointer loads the new start
      pulse_load_a: assert property (@(posedge clock) disable iff (rst)
        start_wr_s ##0 wdata[10] |=> queue_ptr_reset[qi]
          ##1 queue_ptr[10*qi +: 10] == $past(wdata[9:0], 2))
        else $error("pointer not loaded by reset");
      // bit 10 low leaves the pointers alone
      pulse_quiet_a: assert property (@(posedge clock) disable iff (rst)
        start_wr_s ##0 !wdata[10] |=> !queue_ptr_reset[qi])
        else $error("pointer reset without bit 10");
      // end writes never pulse the pointer reset
      end_quiet_a: assert property (@(posedge clock) disable iff (rst)
        end_wr_s |=> !queue_ptr_reset[qi])
        else $error("pointer reset on end write");
      // the pulse clears itself without a new write
      pulse_end_a: assert property (@(posedge clock) disable iff (rst)
        queue_ptr_reset[qi] && !wr |=> !queue_ptr_reset[qi])
        else $error("pointer reset pulse stuck");
      // ordinary step adds one
      ptr_step_a: assert property (@(posedge clock) disable iff (rst)
        mid_step_s |=> queue_ptr[10*qi +: 10] == 10'($past(queue_ptr[10*qi +: 10]) + 10'h001))
        else $error("pointer step wrong");
      // step at the end address wraps to the start
      ptr_wrap_q_a: assert property (@(posedge clock) disable iff (rst)
        ptr_advance[qi] && !queue_ptr_reset[qi] &&
          queue_ptr[10*qi +: 10] == region_bounds[20*qi +: 10]
        |=> queue_ptr[10*qi +: 10] == $past(region_bounds[20*qi+10 +: 10]))
        else $error("pointer did not wrap");
      // no step and no reset keeps the pointer
      ptr_hold_a: assert property (@(posedge clock) disable iff (rst)
        !ptr_advance[qi] && !queue_ptr_reset[qi] |=> $stable(queue_ptr[10*qi +: 10]))
        else $error("pointer moved while idle");
    end
  endgenerate

  // per-LAN-queue watermark checks against the shared threshold
  genvar li;
  generate
    for (li = 0; li < QUEUES; li++) begin : g_mark_chk
      // enabled queue at or below the shared mark
      sequence near_full_s;
        lan_q_enable[li] && lan_q_free_units[li*16 +: 16] <= {3'h0, lan_fill_threshold};
      endsequence
      // pause follows the fill level one cycle later
      pause_set_a: assert property (@(posedge clock) disable iff (rst)
        near_full_s |=> pause_req[li])
        else $error("pause not requested");
      // no pause when disabled or above the mark
      pause_clear_a: assert property (@(posedge clock) disable iff (rst)
        !(lan_q_enable[li] && lan_q_free_units[li*16 +: 16] <= {3'h0, lan_fill_threshold})
        |=> !pause_req[li])
        else $error("pause without fill condition");
      // event only on the first cycle of a pause
      event_edge_a: assert property (@(posedge clock) disable iff (rst)
        wmark_event[li] |-> pause_req[li] && !$past(pause_req[li]))
        else $error("watermark event not at rise");
      // every pause rise carries an event
      event_rise_a: assert property (@(posedge clock) disable iff (rst)
        $rose(pause_req[li]) |-> wmark_event[li])
        else $error("watermark event missing");
    end
  endgenerate
endmodule : queue_region_config
`default_nettype wire

// [verification/queue_engine_model.sv]
// queue engine stand-in: pointer steps, queue enables, free levels
// assumes the bench sets base, en_in and step_req just after an edge
`timescale 1ns/10ps
`default_nettype none
module queue_engine_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] base,
  input wire logic [15:0] en_in,
  input wire logic [3:0] step_req,
  output logic [3:0] ptr_advance,
  output logic [15:0] lan_q_enable,
  output logic [255:0] lan_q_free_units
);
  // queue i reports base plus i free units, one cycle late
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_advance <= 4'h0;
      lan_q_enable <= 16'h0000;
      lan_q_free_units <= '0;
    end else begin
      ptr_advance <= step_req;
      lan_q_enable <= en_in;
      for (int i = 0; i < 16; i++) begin
        lan_q_free_units[16*i +: 16] <= base + 16'(i);
      end
    end
  end
endmodule : queue_engine_model
`default_nettype wire

// [verification/tb_sdram_queue_region_config.sv]
// bench for the queue region bank: register access, pointer pulses,
// wrap, watermark; assumes the strobe bus and the queue engine model
`include "queue_region_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_sdram_queue_region_config;
  logic clock, rst, wr, rd, all_rst;
  logic [8:0] addr, misc_o;
  logic [15:0] wdata, rdata, v, base, en_in, lq_en, pause_req, wmark_event, ev_last;
  logic [3:0] step_req, adv, queue_ptr_reset, rs_last;
  logic [255:0] free_u;
  logic [9:0] q16_end;
  logic [79:0] region_bounds;
  logic [39:0] queue_ptr;
  logic [12:0] thr;
  int bad_count, compares, cycles, rs_cnt, all_cnt, ev_cnt, n;
  queue_engine_model u_model (.clock(clock), .rst(rst), .base(base), .en_in(en_in),
    .step_req(step_req), .ptr_advance(adv), .lan_q_enable(lq_en), .lan_q_free_units(free_u));
  queue_region_config u_dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .ptr_advance(adv), .lan_q_enable(lq_en), .lan_q_free_units(free_u),
    .rdata(rdata), .wan_q16_end_field(q16_end), .region_bounds(region_bounds),
    .queue_ptr(queue_ptr), .queue_ptr_reset(queue_ptr_reset), .all_queue_ptr_reset(all_rst),
    .lan_fill_threshold(thr), .pause_req(pause_req), .wmark_event(wmark_event),
    .partial_frame_purge_off(misc_o[8]), .wan_overflow_drop_off(misc_o[7]),
    .wan_ins_rr_weight(misc_o[6:5]), .wan_ins_encap_select(misc_o[4:3]),
    .wan_ins_priority_level(misc_o[2]), .wan_ins_enable(misc_o[1]),
    .wan_preemptive_drop(misc_o[0]));
  // clock source
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic stop_test();
    $display("counts: compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one write cycle, returns once its effect has landed
  task automatic wr_reg(input logic [8:0] a, input logic [15:0] dv);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
    #1;
  endtask : wr_reg
  // one read cycle, data sampled in the cycle after the strobe
  task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clock);
  endtask : rd_chk
  // hold a step request for k cycles, then let it settle
  task automatic step(input int q, input int k);
    step_req <= 4'(1 << q);
    repeat (k) @(posedge clock);
    step_req <= 4'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask : step
  function automatic logic [9:0] lowv(input int i, input int p);
    return 10'(i * 73 + 5) ^ {10{p[0]}};
  endfunction : lowv
  // pulse monitors and hang guard
  always @(posedge clock) begin
    cycles++;
    if (|queue_ptr_reset) begin
      rs_cnt++;
      rs_last = queue_ptr_reset;
    end
    if (all_rst === 1'b1) all_cnt++;
    if (|wmark_event) begin
      ev_cnt++;
      ev_last = wmark_event;
    end
    if (cycles == 4000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    {wr, rd, addr, wdata, en_in, step_req} = '0;
    base = 16'hff00;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // reset values, last address unmapped
    for (int i = 0; i < 12; i++) rd_chk(`WAN_Q16_END_OFS + 9'(2 * i), 16'h0000);
    $display("test reset done");
    // readback with reserved bits set, both polarities
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 11; i++) begin
        v = {6'h3e, lowv(i, p)};
        wr_reg(`WAN_Q16_END_OFS + 9'(2 * i), v);
        rd_chk(`WAN_Q16_END_OFS + 9'(2 * i), v & (i == 9 ? 16'h1fff : i == 10 ? 16'h03fe : 16'h03ff));
      end
      check(16'(q16_end), 16'(lowv(0, p)));
      for (int q = 0; q < 4; q++) begin
        check(16'(region_bounds[20*q+10 +: 10]), 16'(lowv(1 + 2 * q, p)));
        check(16'(region_bounds[20*q +: 10]), 16'(lowv(2 + 2 * q, p)));
      end
      check(16'(thr), 16'h1800 | 16'(lowv(9, p)));
      check(16'(misc_o), 16'(lowv(10, p) >> 1));
    end
    $display("test readback done");
    // pointer reset pulse, quiet rewrite, wrap at end
    for (int q = 0; q < 4; q++) begin
      wr_reg(`LAN_INS_END_OFS + 9'(4 * q), 16'(q + 10));
      n = rs_cnt;
      wr_reg(`LAN_INS_START_OFS + 9'(4 * q), 16'h0400 | 16'(q + 8));
      check(16'(rs_cnt - n), 16'h0001);
      check(16'(rs_last), 16'(1 << q));
      check(16'(queue_ptr[10*q +: 10]), 16'(q + 8));
      step(q, 1);
      wr_reg(`LAN_INS_START_OFS + 9'(4 * q), 16'(q + 8));
      check(16'(rs_cnt - n), 16'h0001);
      check(16'(queue_ptr[10*q +: 10]), 16'(q + 9));
      step(q, 2);
      check(16'(queue_ptr[10*q +: 10]), 16'(q + 8));
    end
    step(0, 1);
    n = all_cnt;
    wr_reg(`MISC_CTRL_OFS, 16'h0001);
    check(16'(all_cnt - n), 16'h0001);
    check(16'(queue_ptr[9:0]), 16'h0008);
    $display("test pointers done");
    // shared watermark, queue 3 disabled
    wr_reg(`LAN_WMARK_OFS, 16'd57);
    n = ev_cnt;
    en_in <= 16'hfff7;
    base <= 16'd50;
    repeat (4) @(posedge clock);
    #1;
    check(pause_req, 16'h00f7);
    check(ev_last, 16'h00f7);
    check(16'(ev_cnt - n), 16'h0001);
    wr_reg(`LAN_WMARK_OFS, 16'd49);
    repeat (2) @(posedge clock);
    #1;
    check(pause_req, 16'h0000);
    $display("test watermark done");
    stop_test();
  end
endmodule : tb_sdram_queue_region_config
`default_nettype wire
